//--- fbd_pkg.sv
// shared constants for the fieldbus parameter and command word decoder
package fbd_pkg;
  // request function codes
  localparam logic [7:0]  FC_READ_COILS   = 8'h01;
  localparam logic [7:0]  FC_READ_HOLD    = 8'h03;
  localparam logic [7:0]  FC_WRITE_COIL   = 8'h05;
  localparam logic [7:0]  FC_WRITE_REG    = 8'h06;
  localparam logic [7:0]  FC_WRITE_COILS  = 8'h0F;
  localparam logic [7:0]  FC_WRITE_REGS   = 8'h10;
  // exception answer
  localparam logic [7:0]  EXC_NONE        = 8'h00;
  localparam logic [7:0]  EXC_FUNC        = 8'h01;
  localparam logic [7:0]  EXC_ADDR        = 8'h02;
  localparam logic [7:0]  EXC_VALUE       = 8'h03;
  localparam logic [7:0]  EXC_FAIL        = 8'h04;
  localparam logic [7:0]  EXC_FLAG        = 8'h80;
  // holding register and coil map
  localparam logic [15:0] ADDR_INDEX      = 16'h0009;
  localparam logic [15:0] ADDR_PAR_MIN    = 16'h000A;
  localparam logic [15:0] ADDR_PAR_MAX    = 16'hC346;
  localparam logic [15:0] ADDR_CW         = 16'hC350;
  localparam logic [15:0] PAR_STRIDE      = 16'h000A;
  localparam logic [15:0] ADDR_COIL_NV    = 16'h0040;
  localparam logic [15:0] COIL_ON         = 16'hFF00;
  localparam logic [15:0] COIL_OFF        = 16'h0000;
  localparam logic [15:0] QTY_MIN         = 16'h0001;
  localparam logic [15:0] QTY_READ_MAX    = 16'h000A;
  localparam logic [15:0] QTY_WRITE_MAX   = 16'h0002;
  localparam logic [15:0] INDEX_RESET     = 16'h0000;
  localparam logic [4:0]  TEXT_MAX_CHARS  = 5'h14;
  localparam logic [7:0]  CHAR_SPACE      = 8'h20;
  // command word bit positions
  localparam int CW_PRE0   = 0;
  localparam int CW_PRE1   = 1;
  localparam int CW_DC     = 2;
  localparam int CW_COAST  = 3;
  localparam int CW_QSTOP  = 4;
  localparam int CW_FREEZE = 5;
  localparam int CW_START  = 6;
  localparam int CW_RESET  = 7;
  localparam int CW_JOG    = 8;
  localparam int CW_RAMP2  = 9;
  localparam int CW_VALID  = 10;
  localparam int CW_RELAY1 = 11;
  localparam int CW_RELAY2 = 12;
  localparam int CW_SET0   = 13;
  localparam int CW_SET1   = 14;
  localparam int CW_REV    = 15;
  localparam logic [15:0] CW_RESET_VAL = 16'h003C;
  // digital input pins, active high requests
  localparam int DI_PRE0 = 0;
  localparam int DI_PRE1 = 1;
  localparam int DI_DC   = 2;
  localparam int DI_COAST = 3;
  localparam int DI_QSTOP = 4;
  localparam int DI_START = 5;
  localparam int DI_RESET = 6;
  localparam int DI_SET0 = 7;
  localparam int DI_SET1 = 8;
  localparam int NUM_DI  = 9;
  // gating selection slots, two bits each
  localparam int GS_PRESET = 0;
  localparam int GS_DC     = 1;
  localparam int GS_COAST  = 2;
  localparam int GS_START  = 3;
  localparam int GS_RESET  = 4;
  localparam int GS_SETUP  = 5;
  localparam int NUM_GS    = 6;
  localparam logic [1:0] GATE_DI  = 2'h0;
  localparam logic [1:0] GATE_BUS = 2'h1;
  localparam logic [1:0] GATE_AND = 2'h2;
  localparam logic [1:0] GATE_OR  = 2'h3;
endpackage : fbd_pkg

//--- fbd_cw_decoder.sv
// command word latch, digital input gating and drive command decode
`timescale 1ns/100ps
module fbd_cw_decoder (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        cw_wr,
  input  wire logic [15:0] cw_wdata,
  input  wire logic [8:0]  di_pin,
  input  wire logic [11:0] gate_sel,
  output logic [15:0]      drive_command_word,
  output logic [1:0]       preset_sel,
  output logic             dc_brake,
  output logic             coast,
  output logic             quick_stop,
  output logic             freeze_freq,
  output logic             start_enable,
  output logic [1:0]       setup_sel,
  output logic             trip_reset,
  output logic             jog,
  output logic             ramp2_sel,
  output logic             relay1_on,
  output logic             relay2_on,
  output logic             reverse
);
  logic [8:0]  s1_q, s2_q, s3_q, di_q;
  logic [15:0] cw_q;
  logic        rst_lvl_q;
  logic        g_pre0, g_pre1, g_dc, g_coast, g_start, g_rst, g_set0, g_set1, frz, rst_lvl;

  function automatic logic gate(input logic [1:0] sel, input logic di, input logic bus);
    unique case (sel)
      fbd_pkg::GATE_DI:  gate = di;
      fbd_pkg::GATE_BUS: gate = bus;
      fbd_pkg::GATE_AND: gate = di & bus;
      fbd_pkg::GATE_OR:  gate = di | bus;
    endcase
  endfunction : gate

  // pins come from outside: three stages, accept once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= di_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < fbd_pkg::NUM_DI; gi++) begin : g_di
      always_ff @(posedge clk) begin
        if (srst) di_q[gi] <= 1'b0;
        else if (s2_q[gi] == s3_q[gi]) di_q[gi] <= s3_q[gi];
      end
    end
  endgenerate

  // a word with the valid bit low leaves the previous command standing
  always_ff @(posedge clk) begin
    if (srst) cw_q <= fbd_pkg::CW_RESET_VAL;
    else if (cw_wr && cw_wdata[fbd_pkg::CW_VALID]) cw_q <= cw_wdata;
  end

  // bus bits that are active low are turned to active high requests first
  assign g_pre0  = gate(gate_sel[2*fbd_pkg::GS_PRESET +: 2], di_q[fbd_pkg::DI_PRE0],
                        cw_q[fbd_pkg::CW_PRE0]);
  assign g_pre1  = gate(gate_sel[2*fbd_pkg::GS_PRESET +: 2], di_q[fbd_pkg::DI_PRE1],
                        cw_q[fbd_pkg::CW_PRE1]);
  assign g_dc    = gate(gate_sel[2*fbd_pkg::GS_DC +: 2], di_q[fbd_pkg::DI_DC],
                        ~cw_q[fbd_pkg::CW_DC]);
  assign g_coast = gate(gate_sel[2*fbd_pkg::GS_COAST +: 2], di_q[fbd_pkg::DI_COAST],
                        ~cw_q[fbd_pkg::CW_COAST]);
  assign g_start = gate(gate_sel[2*fbd_pkg::GS_START +: 2], di_q[fbd_pkg::DI_START],
                        cw_q[fbd_pkg::CW_START]);
  assign g_rst   = gate(gate_sel[2*fbd_pkg::GS_RESET +: 2], di_q[fbd_pkg::DI_RESET],
                        cw_q[fbd_pkg::CW_RESET]);
  assign g_set0  = gate(gate_sel[2*fbd_pkg::GS_SETUP +: 2], di_q[fbd_pkg::DI_SET0],
                        cw_q[fbd_pkg::CW_SET0]);
  assign g_set1  = gate(gate_sel[2*fbd_pkg::GS_SETUP +: 2], di_q[fbd_pkg::DI_SET1],
                        cw_q[fbd_pkg::CW_SET1]);
  assign frz     = ~cw_q[fbd_pkg::CW_FREEZE];
  assign rst_lvl = g_rst;

  always_ff @(posedge clk) begin
    if (srst) begin
      preset_sel   <= 2'h0;
      dc_brake     <= 1'b0;
      coast        <= 1'b0;
      quick_stop   <= 1'b0;
      freeze_freq  <= 1'b0;
      start_enable <= 1'b0;
      setup_sel    <= 2'h0;
      trip_reset   <= 1'b0;
      rst_lvl_q    <= 1'b0;
    end else begin
      preset_sel   <= {g_pre1, g_pre0};
      dc_brake     <= g_dc;
      // a reset-and-coast input also lets the motor coast while frozen
      coast        <= g_coast | (frz & di_q[fbd_pkg::DI_RESET]);
      // quick stop cannot stop a frozen drive
      quick_stop   <= ~cw_q[fbd_pkg::CW_QSTOP] & ~frz;
      freeze_freq  <= frz;
      // coast from the bus or the coast input blocks start at once; ramp stop is ignored while frozen
      start_enable <= ~g_coast & ~g_dc & (g_start | frz);
      setup_sel    <= {g_set1, g_set0};
      rst_lvl_q    <= rst_lvl;
      trip_reset   <= rst_lvl & ~rst_lvl_q;
    end
  end

  assign drive_command_word = cw_q;
  assign jog       = cw_q[fbd_pkg::CW_JOG];
  assign ramp2_sel = cw_q[fbd_pkg::CW_RAMP2];
  assign relay1_on = cw_q[fbd_pkg::CW_RELAY1];
  assign relay2_on = cw_q[fbd_pkg::CW_RELAY2];
  assign reverse   = cw_q[fbd_pkg::CW_REV];
endmodule : fbd_cw_decoder

//--- fbd_request_handler.sv
`timescale 1ns/100ps
module fbd_request_handler (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        cfg_ready,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_qty,
  input  wire logic [7:0]  req_byte_cnt,
  input  wire logic [31:0] req_wdata,
  output logic             par_req,
  output logic             par_we,
  output logic [15:0]      parameter_number,
  output logic [15:0]      array_element_index,
  output logic [3:0]       par_word,
  output logic [1:0]       par_words,
  output logic             par_nv,
  output logic [31:0]      par_wdata,
  input  wire logic        par_ack,
  input  wire logic        par_err,
  input  wire logic        par_text,
  input  wire logic [4:0]  par_text_len,
  input  wire logic [15:0] par_rdata,
  output logic             rsp_word_valid,
  output logic [15:0]      rsp_word,
  output logic             rsp_done,
  output logic [7:0]       rsp_func,
  output logic [7:0]       rsp_exc_code,
  output logic [7:0]       rsp_byte_cnt,
  input  wire logic [8:0]  di_pin,
  input  wire logic [11:0] gate_sel,
  output logic [15:0]      drive_command_word,
  output logic [1:0]       preset_sel,
  output logic             dc_brake,
  output logic             coast,
  output logic             quick_stop,
  output logic             freeze_freq,
  output logic             start_enable,
  output logic [1:0]       setup_sel,
  output logic             trip_reset,
  output logic             jog,
  output logic             ramp2_sel,
  output logic             relay1_on,
  output logic             relay2_on,
  output logic             reverse
);
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_PAR, ST_DONE} fbd_state_t;

  fbd_state_t  state_q;
  logic [7:0]  func_q, exc_q, exc_d, bcnt_q;
  logic [15:0] addr_q, qty_q, index_q, pnum_q;
  logic [31:0] wdata_q;
  logic        nv_q, cw_wr_q, we_q;
  logic [15:0] cw_wdata_q;
  logic [3:0]  word_q;
  logic [15:0] pnum_d;
  logic [15:0] addr_rem;
  logic        is_par, is_index, is_cw, qty_read_ok, qty_wr_ok, bcnt_ok, last_word;
  logic [5:0]  char_pos;
  logic [7:0]  char_hi, char_lo;
  logic [7:0]  rsp_func_d;

  // a request that arrives while busy is dropped, never queued
  assign req_ready = (state_q == ST_IDLE);

  // parameter number from the register address
  assign pnum_d   = addr_q / fbd_pkg::PAR_STRIDE;
  assign addr_rem = addr_q % fbd_pkg::PAR_STRIDE;
  // addresses between two parameters answer as illegal addresses
  assign is_par   = (addr_rem == 16'h0000) && (addr_q >= fbd_pkg::ADDR_PAR_MIN)
                    && (addr_q <= fbd_pkg::ADDR_PAR_MAX);
  assign is_index = (addr_q == fbd_pkg::ADDR_INDEX);
  assign is_cw    = (addr_q == fbd_pkg::ADDR_CW);
  assign qty_read_ok = (qty_q >= fbd_pkg::QTY_MIN) && (qty_q <= fbd_pkg::QTY_READ_MAX);
  assign qty_wr_ok   = (qty_q >= fbd_pkg::QTY_MIN) && (qty_q <= fbd_pkg::QTY_WRITE_MAX);
  assign bcnt_ok     = ({8'h00, bcnt_q} == {qty_q[14:0], 1'b0});

  // decision order follows the usual slave order: function, value, address
  always_comb begin
    exc_d = fbd_pkg::EXC_NONE;
    unique case (func_q)
      fbd_pkg::FC_READ_HOLD: begin
        if (!cfg_ready) exc_d = fbd_pkg::EXC_FUNC;
        else if (!qty_read_ok) exc_d = fbd_pkg::EXC_VALUE;
        else if (is_index && qty_q != fbd_pkg::QTY_MIN) exc_d = fbd_pkg::EXC_ADDR;
        else if (!is_par && !is_index) exc_d = fbd_pkg::EXC_ADDR;
      end
      fbd_pkg::FC_WRITE_REG: begin
        if (!cfg_ready) exc_d = fbd_pkg::EXC_FUNC;
        else if (!is_par && !is_index && !is_cw) exc_d = fbd_pkg::EXC_ADDR;
      end
      fbd_pkg::FC_WRITE_REGS: begin
        if (!cfg_ready) exc_d = fbd_pkg::EXC_FUNC;
        else if (!qty_wr_ok || !bcnt_ok) exc_d = fbd_pkg::EXC_VALUE;
        else if ((is_index || is_cw) && qty_q != fbd_pkg::QTY_MIN)
          exc_d = fbd_pkg::EXC_ADDR;
        else if (!is_par && !is_index && !is_cw) exc_d = fbd_pkg::EXC_ADDR;
      end
      fbd_pkg::FC_WRITE_COIL: begin
        if (!cfg_ready) exc_d = fbd_pkg::EXC_FUNC;
        else if (wdata_q[15:0] != fbd_pkg::COIL_ON && wdata_q[15:0] != fbd_pkg::COIL_OFF)
          exc_d = fbd_pkg::EXC_VALUE;
        else if (addr_q != fbd_pkg::ADDR_COIL_NV) exc_d = fbd_pkg::EXC_ADDR;
      end
      default: exc_d = fbd_pkg::EXC_FUNC;
    endcase
  end

  // text bytes: two characters per register, high byte first
  assign char_pos  = {1'b0, word_q, 1'b0};
  assign char_hi   = (par_text && char_pos >= {1'b0, par_text_len})
                     ? fbd_pkg::CHAR_SPACE : par_rdata[15:8];
  assign char_lo   = (par_text && (char_pos + 6'h01) >= {1'b0, par_text_len})
                     ? fbd_pkg::CHAR_SPACE : par_rdata[7:0];
  // a text answer stops at the stored length, never past twenty characters
  assign last_word = ({12'h000, word_q} + 16'h0001 == qty_q)
                     || (par_text && (char_pos + 6'h02) >= {1'b0, par_text_len})
                     || (par_text && (char_pos + 6'h02) >= {1'b0, fbd_pkg::TEXT_MAX_CHARS});

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE:  if (req_valid) state_q <= ST_CHECK;
        ST_CHECK: begin
          // index, command word and coil requests finish without the store
          if (exc_d != fbd_pkg::EXC_NONE || !is_par) state_q <= ST_DONE;
          else state_q <= ST_PAR;
        end
        ST_PAR: begin
          // no timeout: a store that never answers keeps the handler busy
          if (par_ack && (par_err || we_q || last_word)) state_q <= ST_DONE;
        end
        ST_DONE:  state_q <= ST_IDLE;
      endcase
    end
  end

  // request capture
  always_ff @(posedge clk) begin
    if (srst) begin
      func_q  <= 8'h00;
      addr_q  <= 16'h0000;
      qty_q   <= 16'h0000;
      bcnt_q  <= 8'h00;
      wdata_q <= 32'h0000_0000;
    end else if (state_q == ST_IDLE && req_valid) begin
      func_q  <= req_func;
      addr_q  <= req_addr;
      // functions without a count field move one register
      qty_q   <= (req_func == fbd_pkg::FC_WRITE_REGS || req_func == fbd_pkg::FC_READ_HOLD)
                 ? req_qty : fbd_pkg::QTY_MIN;
      bcnt_q  <= req_byte_cnt;
      wdata_q <= req_wdata;
    end
  end

  // local registers: array index and storage target coil
  always_ff @(posedge clk) begin
    if (srst) begin
      index_q <= fbd_pkg::INDEX_RESET;
      nv_q    <= 1'b0;
    end else if (state_q == ST_CHECK && exc_d == fbd_pkg::EXC_NONE) begin
      if (is_index && (func_q == fbd_pkg::FC_WRITE_REG || func_q == fbd_pkg::FC_WRITE_REGS))
        index_q <= wdata_q[15:0];
      // the coil stands for every later parameter write until rewritten
      if (func_q == fbd_pkg::FC_WRITE_COIL)
        nv_q <= (wdata_q[15:0] == fbd_pkg::COIL_ON);
    end
  end

  // command word writes go to the decoder as a one-cycle strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      cw_wr_q    <= 1'b0;
      cw_wdata_q <= 16'h0000;
    end else begin
      cw_wr_q    <= (state_q == ST_CHECK) && (exc_d == fbd_pkg::EXC_NONE) && is_cw;
      cw_wdata_q <= wdata_q[15:0];
    end
  end

  // parameter store handshake: request held until acknowledged
  always_ff @(posedge clk) begin
    if (srst) begin
      par_req <= 1'b0;
      we_q    <= 1'b0;
      pnum_q  <= 16'h0000;
      word_q  <= 4'h0;
    end else if (state_q == ST_CHECK) begin
      par_req <= (exc_d == fbd_pkg::EXC_NONE) && is_par;
      we_q    <= (func_q != fbd_pkg::FC_READ_HOLD);
      pnum_q  <= pnum_d;
      word_q  <= 4'h0;
    end else if (state_q == ST_PAR && par_ack) begin
      par_req <= !(par_err || we_q || last_word);
      word_q  <= word_q + 4'h1;
    end
  end

  assign par_we              = we_q;
  assign parameter_number    = pnum_q;
  assign array_element_index = index_q;
  assign par_word            = word_q;
  assign par_nv              = nv_q;
  // one word goes when the register count is one, two when the count is two
  assign par_words           = (qty_q == fbd_pkg::QTY_WRITE_MAX) ? 2'h2 : 2'h1;
  assign par_wdata           = (qty_q == fbd_pkg::QTY_WRITE_MAX)
                               ? wdata_q : {16'h0000, wdata_q[15:0]};

  // an exception answer echoes the function with its top bit set
  assign rsp_func_d = (exc_q != fbd_pkg::EXC_NONE) ? (func_q | fbd_pkg::EXC_FLAG)
                                                   : func_q;

  // answer side: words stream out, then one done pulse carries the header
  always_ff @(posedge clk) begin
    if (srst) begin
      exc_q          <= fbd_pkg::EXC_NONE;
      rsp_word_valid <= 1'b0;
      rsp_word       <= 16'h0000;
      rsp_byte_cnt   <= 8'h00;
      rsp_done       <= 1'b0;
      rsp_func       <= 8'h00;
      rsp_exc_code   <= 8'h00;
    end else begin
      rsp_word_valid <= 1'b0;
      rsp_done       <= 1'b0;
      if (state_q == ST_CHECK) begin
        exc_q        <= exc_d;
        rsp_byte_cnt <= 8'h00;
        if (exc_d == fbd_pkg::EXC_NONE && is_index && func_q == fbd_pkg::FC_READ_HOLD) begin
          rsp_word_valid <= 1'b1;
          rsp_word       <= index_q;
          rsp_byte_cnt   <= 8'h02;
        end
      end else if (state_q == ST_PAR && par_ack) begin
        // store data is promised only with the acknowledge, so it is taken on that edge
        if (par_err) begin
          exc_q        <= fbd_pkg::EXC_FAIL;
          // an exception answer carries no data, so the streamed count is dropped
          rsp_byte_cnt <= 8'h00;
        end else if (!we_q) begin
          rsp_word_valid <= 1'b1;
          rsp_word       <= {char_hi, char_lo};
          rsp_byte_cnt   <= rsp_byte_cnt + 8'h02;
        end
      end else if (state_q == ST_DONE) begin
        rsp_done     <= 1'b1;
        rsp_func     <= rsp_func_d;
        rsp_exc_code <= exc_q;
      end
    end
  end

  fbd_cw_decoder u_cw (
    .clk                (clk),
    .srst               (srst),
    .cw_wr              (cw_wr_q),
    .cw_wdata           (cw_wdata_q),
    .di_pin             (di_pin),
    .gate_sel           (gate_sel),
    .drive_command_word (drive_command_word),
    .preset_sel         (preset_sel),
    .dc_brake           (dc_brake),
    .coast              (coast),
    .quick_stop         (quick_stop),
    .freeze_freq        (freeze_freq),
    .start_enable       (start_enable),
    .setup_sel          (setup_sel),
    .trip_reset         (trip_reset),
    .jog                (jog),
    .ramp2_sel          (ramp2_sel),
    .relay1_on          (relay1_on),
    .relay2_on          (relay2_on),
    .reverse            (reverse)
  );
endmodule : fbd_request_handler

//--- fbd_store_model.sv
// parameter store stand-in on the handler's store port
`timescale 1ns/100ps
module fbd_store_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        slow,
  input  wire logic        par_req,
  input  wire logic [15:0] parameter_number,
  input  wire logic [15:0] array_element_index,
  input  wire logic [3:0]  par_word,
  output logic             par_ack,
  output logic             par_err,
  output logic             par_text,
  output logic [4:0]       par_text_len,
  output logic [15:0]      par_rdata
);
  logic [2:0]  cnt_q;
  logic [15:0] val;
  always_ff @(posedge clk) begin
    if (srst || !par_req || par_ack) begin
      cnt_q   <= 3'h0;
      par_ack <= 1'b0;
    end else if (cnt_q == (slow ? 3'h4 : 3'h0)) begin
      par_ack <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // parameter 7 holds three characters; bytes past the end are junk, not spaces
  assign par_text     = (parameter_number == 16'h0007);
  assign par_text_len = 5'h03;
  assign val = par_text ? (par_word == 4'h0 ? 16'h4142 : (par_word == 4'h1 ? 16'h43FF : 16'hFFFF))
             : {parameter_number[7:0], par_word, array_element_index[3:0]};
  // data is only promised with the acknowledge, so it is scrambled otherwise
  assign par_rdata = par_ack ? val : ~val;
  assign par_err   = par_ack && (parameter_number == 16'h0063);
endmodule : fbd_store_model

//--- fbd_request_handler_chk.sv
// concurrent checks on the request handler ports
`timescale 1ns/100ps
module fbd_request_handler_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        cfg_ready,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [7:0]  req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_qty,
  input wire logic        par_req,
  input wire logic [15:0] parameter_number,
  input wire logic        par_ack,
  input wire logic        par_err,
  input wire logic        rsp_done,
  input wire logic [7:0]  rsp_func,
  input wire logic [7:0]  rsp_exc_code,
  input wire logic [7:0]  rsp_byte_cnt,
  input wire logic        trip_reset
);
  logic        take;
  logic [15:0] addr_q;
  assign take = req_valid && req_ready;
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_q <= 16'h0000;
    end else if (take) begin
      addr_q <= req_addr;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_exc_top_bit: assert property (rsp_done && rsp_exc_code != 8'h00 |-> rsp_func[7])
    else $error("exception answer without flagged function");
  a_exc_code_range: assert property (rsp_done |-> rsp_exc_code <= 8'h04)
    else $error("exception code out of range");
  a_exc_no_data: assert property (rsp_done && rsp_exc_code != 8'h00
    |-> rsp_byte_cnt == 8'h00)
    else $error("exception answer carries data");
  a_take_answered: assert property (take |=> !req_ready ##[2:60] rsp_done)
    else $error("request not answered in time");
  a_param_number: assert property (par_req |-> parameter_number * 16'h000A == addr_q)
    else $error("parameter number not address over ten");
  a_unconfigured: assert property (take && !cfg_ready
    |-> ##3 rsp_done && rsp_exc_code == 8'h01)
    else $error("unconfigured request not refused");
  a_read_qty: assert property (take && cfg_ready && req_func == 8'h03
    && (req_qty == 16'h0000 || req_qty > 16'h000A) |-> ##3 rsp_done && rsp_exc_code == 8'h03)
    else $error("bad read length not refused");
  a_store_fail: assert property (par_req && par_ack && par_err |-> ##[1:4] rsp_done
    && rsp_exc_code == 8'h04)
    else $error("store failure not reported");
  a_trip_pulse: assert property (trip_reset |=> !trip_reset)
    else $error("trip reset longer than one cycle");
endmodule : fbd_request_handler_chk
bind fbd_request_handler fbd_request_handler_chk u_chk (.*);

//--- tb.sv
// self-checking bench for the request handler
`timescale 1ns/100ps
`define CK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb;
  logic        clk, srst, cfg_ready, req_valid, req_ready, par_req, par_we, par_nv, par_ack;
  logic        par_err, par_text, rsp_word_valid, rsp_done, slow, dc_brake, coast, quick_stop;
  logic        freeze_freq, start_enable, trip_reset, jog, ramp2_sel, relay1_on, relay2_on;
  logic        reverse;
  logic [7:0]  req_func, req_byte_cnt, rsp_func, rsp_exc_code, rsp_byte_cnt;
  logic [15:0] req_addr, req_qty, parameter_number, array_element_index, par_rdata, rsp_word;
  logic [15:0] drive_command_word;
  logic [31:0] req_wdata, par_wdata;
  logic [3:0]  par_word;
  logic [1:0]  par_words, preset_sel, setup_sel;
  logic [4:0]  par_text_len;
  logic [8:0]  di_pin;
  logic [11:0] gate_sel;
  int          fail_count, checks, trips;
  logic [15:0] words[$];
  fbd_request_handler uut (.*);
  fbd_store_model u_store (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (trip_reset === 1'b1) trips++;
  task automatic xp(string n, logic [7:0] f, logic [15:0] a, q, logic [7:0] b,
                    logic [31:0] w, logic [7:0] exc);
    int k;
    @(posedge clk);
    {req_valid, req_func, req_addr, req_qty, req_byte_cnt, req_wdata} <= {1'b1, f, a, q, b, w};
    @(posedge clk);
    req_valid <= 1'b0;
    words.delete();
    k = 0;
    do begin
      @(posedge clk);
      #1;
      if (rsp_word_valid === 1'b1) words.push_back(rsp_word);
      k++;
    end while (rsp_done !== 1'b1 && k < 80);
    `CK(n, 1'b1, rsp_done)
    `CK(n, exc, rsp_exc_code)
    `CK(n, (exc != 8'h00) ? (f | 8'h80) : f, rsp_func)
    if (exc != 8'h00) `CK(n, 8'h00, rsp_byte_cnt)
  endtask : xp
  task automatic cw(logic [15:0] w);
    xp("cw", 8'h06, 16'hC350, 16'h0001, 8'h00, {16'h0000, w}, 8'h00);
    repeat (4) @(posedge clk);
    #1;
  endtask : cw
  task automatic t_exc;
    cfg_ready <= 1'b0;
    xp("cfg", 8'h03, 16'h000A, 16'h0001, 8'h00, 32'h0, 8'h01);
    cfg_ready <= 1'b1;
    xp("func", 8'h08, 16'h000A, 16'h0001, 8'h00, 32'h0, 8'h01);
    xp("qty0", 8'h03, 16'h000A, 16'h0000, 8'h00, 32'h0, 8'h03);
    xp("qty11", 8'h03, 16'h000A, 16'h000B, 8'h00, 32'h0, 8'h03);
    xp("coil", 8'h05, 16'h0040, 16'h0000, 8'h00, 32'h1234, 8'h03);
    xp("addr", 8'h03, 16'h000B, 16'h0001, 8'h00, 32'h0, 8'h02);
    xp("cwrd", 8'h03, 16'hC350, 16'h0001, 8'h00, 32'h0, 8'h02);
    xp("fail", 8'h03, 16'h03DE, 16'h0001, 8'h00, 32'h0, 8'h04);
    $display("test exceptions done");
  endtask : t_exc
  task automatic t_par;
    xp("idx", 8'h06, 16'h0009, 16'h0001, 8'h00, 32'h5, 8'h00);
    `CK("index", 16'h0005, array_element_index)
    slow <= 1'b1;
    xp("rd", 8'h03, 16'h001E, 16'h0001, 8'h00, 32'h0, 8'h00);
    `CK("word", 16'h0305, words[0])
    slow <= 1'b0;
    xp("rd10", 8'h03, 16'h000A, 16'h000A, 8'h00, 32'h0, 8'h00);
    `CK("nwords", 10, words.size())
    `CK("last", 16'h0195, words[9])
    `CK("bytes", 8'h14, rsp_byte_cnt)
    xp("nv1", 8'h05, 16'h0040, 16'h0000, 8'h00, 32'hFF00, 8'h00);
    `CK("nv1", 1'b1, par_nv)
    xp("w32", 8'h10, 16'h0028, 16'h0002, 8'h04, 32'h12345678, 8'h00);
    `CK("words2", 2'h2, par_words)
    `CK("wdata2", 32'h12345678, par_wdata)
    `CK("we", 1'b1, par_we)
    xp("nv0", 8'h05, 16'h0040, 16'h0000, 8'h00, 32'h0, 8'h00);
    `CK("nv0", 1'b0, par_nv)
    xp("w16", 8'h06, 16'h0014, 16'h0001, 8'h00, 32'h1234, 8'h00);
    `CK("words1", 2'h1, par_words)
    `CK("wdata1", 32'h00001234, par_wdata)
    slow <= 1'b1;
    xp("txt", 8'h03, 16'h0046, 16'h0002, 8'h00, 32'h0, 8'h00);
    `CK("txt0", 16'h4142, words[0])
    `CK("txt1", 16'h4320, words[1])
    slow <= 1'b0;
    $display("test parameters done");
  endtask : t_par
  task automatic t_cw;
    int t0;
    cw(16'h443B);
    `CK("preset", 2'h3, preset_sel)
    `CK("setup", 2'h2, setup_sel)
    `CK("dc", 1'b1, dc_brake)
    cw(16'h0000);
    `CK("cwreg", 16'h443B, drive_command_word)
    cw(16'h0434);
    `CK("coast", 1'b1, coast)
    `CK("start0", 1'b0, start_enable)
    cw(16'h042C);
    `CK("qstop", 1'b1, quick_stop)
    t0 = trips;
    cw(16'h07FC);
    `CK("start1", 1'b1, start_enable)
    `CK("dc0", 1'b0, dc_brake)
    cw(16'h9FFC);
    `CK("trips", t0 + 1, trips)
    `CK("jog", 1'b1, jog)
    `CK("ramp2", 1'b1, ramp2_sel)
    `CK("relay1", 1'b1, relay1_on)
    `CK("relay2", 1'b1, relay2_on)
    `CK("rev", 1'b1, reverse)
    cw(16'h041C);
    `CK("freeze", 1'b1, freeze_freq)
    cw(16'h040C);
    `CK("frz_qs", 1'b0, quick_stop)
    cw(16'h0414);
    `CK("frz_co", 1'b1, coast)
    cw(16'h043C);
    gate_sel <= 12'h545;
    di_pin <= 9'h008;
    repeat (8) @(posedge clk);
    #1;
    `CK("di_co", 1'b1, coast)
    di_pin <= 9'h000;
    repeat (8) @(posedge clk);
    #1;
    `CK("di_off", 1'b0, coast)
    gate_sel <= 12'h567;
    di_pin <= 9'h009;
    repeat (8) @(posedge clk);
    #1;
    `CK("di_or", 2'h1, preset_sel)
    `CK("di_and", 1'b0, coast)
    $display("test command word done");
  endtask : t_cw
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  initial begin
    {srst, cfg_ready, req_valid, slow, di_pin, gate_sel} = {4'b1100, 9'h000, 12'h555};
    {req_func, req_addr, req_qty, req_byte_cnt, req_wdata} = '0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CK("ready", 1'b1, req_ready)
    `CK("cwrst", 16'h003C, drive_command_word)
    `CK("idxrst", 16'h0000, array_element_index)
    `CK("nvrst", 1'b0, par_nv)
    t_exc();
    t_par();
    t_cw();
    test_done();
  end
  initial begin
    #50000;
    fail_count++;
    test_done();
  end
endmodule : tb
